// ==== verilog/phy_init_device.sv ====
`timescale 1ns/1ps
module phy_init_device #(
   parameter int RST_DONE_CYC = phy_init_pkg::RST_DONE_CYC,
   parameter int AN_DONE_CYC  = phy_init_pkg::AN_DONE_CYC,
   parameter int BLINK_CYC    = phy_init_pkg::BLINK_CYC
) (
   // Clock, reset, enable
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       ce,
   // Management link with hardware reset pin
   phy_mgmt_if.dev         mif,
   // Strap pins
   input  wire logic [4:0] strap_phy_addr,
   input  wire logic       strap_rmii,
   // Media-side status
   input  wire logic       link_up,
   input  wire logic       activity,
   input  wire logic       collision,
   // Configuration and status
   output logic [4:0]      phy_address,
   output logic            rmii_mode,
   output logic            init_done,
   output logic            clk_run,
   // LED and shared collision pin
   output logic            led_primary,
   output logic            col_pin,
   output logic            col_pin_oe
);
   typedef enum logic [1:0] {HW_HELD, HW_SETTLE, HW_READY} hw_e;

   hw_e         state;
   hw_e         next_state;
   logic [23:0] cnt;
   logic [23:0] next_cnt;
   logic        next_init_done;

   logic [5:0]  strap_s1;
   logic [5:0]  strap_s2;
   logic [5:0]  strap_s3;
   logic [4:0]  next_phy_address;
   logic        next_rmii_mode;

   logic [15:0] basic_mode_control;
   logic [15:0] next_basic_mode_control;
   logic [15:0] led_multiplex_control;
   logic [15:0] next_led_multiplex_control;
   logic        an_busy;
   logic        next_an_busy;
   logic        an_done;
   logic        next_an_done;
   logic [23:0] an_cnt;
   logic [23:0] next_an_cnt;
   logic        next_ack;
   logic [15:0] next_rdata;
   logic [15:0] rd_val;
   logic        hit;
   logic        sw_rst;
   logic        an_go;

   logic [23:0] blink_cnt;
   logic [23:0] next_blink_cnt;
   logic        blink;
   logic        next_blink;
   logic        act_col;
   logic        next_led_primary;
   logic        next_col_pin;
   logic        next_col_pin_oe;
   logic        next_clk_run;

   // Internal reset sequencing
   always_comb begin
      next_state     = state;
      next_cnt       = cnt;
      next_init_done = init_done;
      if (!mif.hw_reset_n) begin
         next_state     = HW_HELD;
         next_cnt       = '0;
         next_init_done = 1'h0;
      end else begin
         unique case (state)
            HW_HELD: begin
               next_state = HW_SETTLE;
            end
            HW_SETTLE: begin
               if (cnt == 24'(RST_DONE_CYC - 1)) begin
                  next_state     = HW_READY;
                  next_init_done = 1'h1;
               end else begin
                  next_cnt = cnt + 24'h1;
               end
            end
            HW_READY: begin
               next_state = HW_READY;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state     <= HW_HELD;
         cnt       <= '0;
         init_done <= 1'h0;
      end else if (ce) begin
         state     <= next_state;
         cnt       <= next_cnt;
         init_done <= next_init_done;
      end
   end

   // Straps are caught only while the pins are not yet driven as outputs
   always_comb begin
      next_phy_address = phy_address;
      next_rmii_mode   = rmii_mode;
      if (state != HW_READY && strap_s2 == strap_s3) begin
         next_phy_address = strap_s3[4:0];
         next_rmii_mode   = strap_s3[5];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         strap_s1    <= '0;
         strap_s2    <= '0;
         strap_s3    <= '0;
         phy_address <= '0;
         rmii_mode   <= 1'h0;
      end else if (ce) begin
         strap_s1    <= {strap_rmii, strap_phy_addr};
         strap_s2    <= strap_s1;
         strap_s3    <= strap_s2;
         phy_address <= next_phy_address;
         rmii_mode   <= next_rmii_mode;
      end
   end

   // Register read view
   always_comb begin
      rd_val = 16'h0000;
      unique case (mif.reg_addr)
         phy_init_pkg::OFS_BASIC_CTRL: begin
            rd_val = basic_mode_control;
         end
         phy_init_pkg::OFS_BASIC_STATUS: begin
            rd_val[phy_init_pkg::BS_AN_DONE_BIT] = an_done;
            rd_val[phy_init_pkg::BS_LINK_BIT]    = link_up;
         end
         phy_init_pkg::OFS_LED_MUX: begin
            rd_val = led_multiplex_control;
         end
         default: begin
            rd_val = 16'h0000;
         end
      endcase
   end

   // Management access and register side effects
   always_comb begin
      next_basic_mode_control    = basic_mode_control;
      next_led_multiplex_control = led_multiplex_control;
      next_an_busy = an_busy;
      next_an_done = an_done;
      next_an_cnt  = an_cnt;
      next_rdata   = mif.rdata;
      // Requests to another address or during reset get no answer
      hit = mif.req && init_done && mif.phy_addr == phy_address;
      sw_rst = hit && mif.wr &&
         ((mif.reg_addr == phy_init_pkg::OFS_BASIC_CTRL &&
           mif.wdata[phy_init_pkg::BC_RESET_BIT]) ||
          (mif.reg_addr == phy_init_pkg::OFS_RESET_CTRL &&
           (mif.wdata[phy_init_pkg::RC_SW_BIT] ||
            mif.wdata[phy_init_pkg::RC_DIG_BIT])));
      an_go = hit && mif.wr && !sw_rst &&
         mif.reg_addr == phy_init_pkg::OFS_BASIC_CTRL &&
         mif.wdata[phy_init_pkg::BC_AN_EN_BIT] &&
         mif.wdata[phy_init_pkg::BC_AN_RST_BIT];
      next_ack = hit;
      if (an_busy) begin
         if (!link_up) begin
            next_an_cnt = '0;
         end else if (an_cnt == 24'(AN_DONE_CYC - 1)) begin
            next_an_busy = 1'h0;
            next_an_done = 1'h1;
         end else begin
            next_an_cnt = an_cnt + 24'h1;
         end
      end
      if (!link_up) begin
         next_an_done = 1'h0;
      end
      if (hit && mif.wr) begin
         if (mif.reg_addr == phy_init_pkg::OFS_BASIC_CTRL) begin
            next_basic_mode_control =
               mif.wdata & phy_init_pkg::BASIC_CTRL_WMASK;
         end
         if (mif.reg_addr == phy_init_pkg::OFS_LED_MUX) begin
            next_led_multiplex_control = mif.wdata;
         end
      end else if (hit) begin
         next_rdata = rd_val;
      end
      if (an_go) begin
         next_an_busy = 1'h1;
         next_an_cnt  = '0;
         next_an_done = 1'h0;
      end
      if (!init_done || sw_rst) begin
         next_basic_mode_control    = phy_init_pkg::BASIC_CTRL_RESET;
         next_led_multiplex_control = phy_init_pkg::LED_MUX_RESET;
         next_an_busy = 1'h0;
         next_an_done = 1'h0;
         next_an_cnt  = '0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         basic_mode_control    <= phy_init_pkg::BASIC_CTRL_RESET;
         led_multiplex_control <= phy_init_pkg::LED_MUX_RESET;
         an_busy   <= 1'h0;
         an_done   <= 1'h0;
         an_cnt    <= '0;
         mif.ack   <= 1'h0;
         mif.rdata <= 16'h0000;
      end else if (ce) begin
         basic_mode_control    <= next_basic_mode_control;
         led_multiplex_control <= next_led_multiplex_control;
         an_busy   <= next_an_busy;
         an_done   <= next_an_done;
         an_cnt    <= next_an_cnt;
         mif.ack   <= next_ack;
         mif.rdata <= next_rdata;
      end
   end

   // LED routing; the blink phase only advances during activity
   always_comb begin
      next_blink_cnt = '0;
      next_blink     = 1'h0;
      if (activity) begin
         next_blink = blink;
         if (blink_cnt == 24'(BLINK_CYC - 1)) begin
            next_blink_cnt = '0;
            next_blink     = ~blink;
         end else begin
            next_blink_cnt = blink_cnt + 24'h1;
         end
      end
      // Activity may leave the LED only once collision is switched off
      act_col = led_multiplex_control[phy_init_pkg::LM_ACT_COL_BIT] &&
                led_multiplex_control[phy_init_pkg::LM_COL_DIS_BIT];
      next_led_primary = link_up && !(!act_col && activity && blink);
      if (act_col) begin
         next_col_pin = activity && blink;
      end else begin
         next_col_pin = collision &&
            !led_multiplex_control[phy_init_pkg::LM_COL_DIS_BIT];
      end
      next_col_pin_oe = state == HW_READY;
      next_clk_run    = state != HW_HELD;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         blink_cnt   <= '0;
         blink       <= 1'h0;
         led_primary <= 1'h0;
         col_pin     <= 1'h0;
         col_pin_oe  <= 1'h0;
         clk_run     <= 1'h0;
      end else if (ce) begin
         blink_cnt   <= next_blink_cnt;
         blink       <= next_blink;
         led_primary <= next_led_primary;
         col_pin     <= next_col_pin;
         col_pin_oe  <= next_col_pin_oe;
         clk_run     <= next_clk_run;
      end
   end
endmodule : phy_init_device

// ==== verilog/phy_init_pkg.sv ====
// What this block does
// - Reset low at least 1 us restores defaults
// - Every hardware reset resamples the strap pins
// - Internal reset ends about 200 us later
// - Accesses use and match the strapped address
// - Control bit 15 starts a management reset
// - Reset control bits 15, 14 reset device
// - Host waits 500 us after register resets
// - Control bits 12, 8 start auto-negotiation
// - Status bit 5 reports negotiation done; polled
// - Receive-valid strap picks MII or RMII
// - Five address straps latched at hardware reset
// - Primary LED: link steady, activity blinks
// - Activity moves to collision pin, collision off
// - Clocks run whenever not held in reset
package phy_init_pkg;
   localparam int CLK_MHZ          = 50;
   localparam int HWRST_MIN_US     = 1;
   localparam int HWRST_MIN_CYC    = HWRST_MIN_US * CLK_MHZ;
   localparam int RST_DONE_US      = 200;
   localparam int RST_DONE_CYC     = RST_DONE_US * CLK_MHZ;
   localparam int REG_RST_WAIT_US  = 500;
   localparam int REG_RST_WAIT_CYC = REG_RST_WAIT_US * CLK_MHZ;
   localparam int AN_DONE_US       = 100;
   localparam int AN_DONE_CYC      = AN_DONE_US * CLK_MHZ;
   localparam int BLINK_US         = 50000;
   localparam int BLINK_CYC        = BLINK_US * CLK_MHZ;
   localparam int ACK_TIMEOUT_CYC  = 16;

   localparam logic [4:0] OFS_BASIC_CTRL   = 5'h00;
   localparam logic [4:0] OFS_BASIC_STATUS = 5'h01;
   localparam logic [4:0] OFS_LED_MUX      = 5'h18;
   localparam logic [4:0] OFS_RESET_CTRL   = 5'h1F;

   localparam int BC_RESET_BIT  = 15;
   localparam int BC_AN_EN_BIT  = 12;
   localparam int BC_AN_RST_BIT = 8;
   localparam int BS_AN_DONE_BIT = 5;
   localparam int BS_LINK_BIT    = 2;
   localparam int RC_SW_BIT      = 15;
   localparam int RC_DIG_BIT     = 14;
   localparam int LM_ACT_COL_BIT = 0;
   localparam int LM_COL_DIS_BIT = 1;

   localparam logic [15:0] BASIC_CTRL_RESET = 16'h0000;
   localparam logic [15:0] LED_MUX_RESET    = 16'h0000;
   // Self-clearing bits never store
   localparam logic [15:0] BASIC_CTRL_WMASK = 16'h7EFF;

   localparam logic [15:0] HOST_MII_RST_VAL  = 16'h8000;
   localparam logic [15:0] HOST_REG_RST_VAL  = 16'hC000;
   localparam logic [15:0] HOST_AN_START_VAL = 16'h1100;
endpackage : phy_init_pkg

// ==== verilog/phy_mgmt_if.sv ====
`timescale 1ns/1ps
interface phy_mgmt_if;
   logic        hw_reset_n;
   logic        req;
   logic        wr;
   logic [4:0]  phy_addr;
   logic [4:0]  reg_addr;
   logic [15:0] wdata;
   logic        ack;
   logic [15:0] rdata;

   modport dev (
      input  hw_reset_n, req, wr, phy_addr, reg_addr, wdata,
      output ack, rdata
   );
   modport host (
      output hw_reset_n, req, wr, phy_addr, reg_addr, wdata,
      input  ack, rdata
   );
endinterface : phy_mgmt_if

// ==== verilog/phy_init_host.sv ====
`timescale 1ns/1ps
module phy_init_host #(
   parameter int RST_DONE_CYC     = phy_init_pkg::RST_DONE_CYC,
   parameter int REG_RST_WAIT_CYC = phy_init_pkg::REG_RST_WAIT_CYC
) (
   // Clock, reset, enable
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       ce,
   // Management link with hardware reset pin
   phy_mgmt_if.host        mif,
   // User control
   input  wire logic       start,
   input  wire logic [4:0] phy_addr_cfg,
   // User status
   output logic            busy,
   output logic            done,
   output logic            error
);
   typedef enum logic [2:0] {
      H_IDLE, H_PULSE, H_SETTLE, H_MII_RST,
      H_REG_RST, H_WAIT, H_AN_START, H_POLL
   } step_e;

   step_e       step;
   step_e       next_step;
   logic [23:0] cnt;
   logic [23:0] next_cnt;
   logic        pend;
   logic        next_pend;
   logic [4:0]  tmo;
   logic [4:0]  next_tmo;
   logic        next_busy;
   logic        next_done;
   logic        next_error;
   logic        next_hw_reset_n;
   logic        next_req;
   logic        next_wr;
   logic [4:0]  next_phy_addr;
   logic [4:0]  next_reg_addr;
   logic [15:0] next_wdata;

   always_comb begin
      next_step  = step;
      next_cnt   = cnt;
      next_pend  = pend;
      next_tmo   = tmo;
      next_busy  = busy;
      next_done  = done;
      next_error = error;
      next_hw_reset_n = mif.hw_reset_n;
      next_req      = 1'h0;
      next_wr       = mif.wr;
      next_phy_addr = mif.phy_addr;
      next_reg_addr = mif.reg_addr;
      next_wdata    = mif.wdata;
      unique case (step)
         H_IDLE: begin
            if (start) begin
               next_step  = H_PULSE;
               next_cnt   = '0;
               next_busy  = 1'h1;
               next_done  = 1'h0;
               next_error = 1'h0;
               next_hw_reset_n = 1'h0;
               next_phy_addr   = phy_addr_cfg;
            end
         end
         H_PULSE: begin
            if (cnt == 24'(phy_init_pkg::HWRST_MIN_CYC - 1)) begin
               next_hw_reset_n = 1'h1;
               next_cnt  = '0;
               next_step = H_SETTLE;
            end else begin
               next_cnt = cnt + 24'h1;
            end
         end
         H_SETTLE: begin
            if (cnt == 24'(RST_DONE_CYC - 1)) begin
               next_step = H_MII_RST;
            end else begin
               next_cnt = cnt + 24'h1;
            end
         end
         H_WAIT: begin
            if (cnt == 24'(REG_RST_WAIT_CYC - 1)) begin
               next_step = H_AN_START;
            end else begin
               next_cnt = cnt + 24'h1;
            end
         end
         H_MII_RST, H_REG_RST, H_AN_START, H_POLL: begin
            if (!pend) begin
               next_req  = 1'h1;
               next_pend = 1'h1;
               next_tmo  = '0;
               next_wr   = step != H_POLL;
               if (step == H_MII_RST) begin
                  next_reg_addr = phy_init_pkg::OFS_BASIC_CTRL;
                  next_wdata    = phy_init_pkg::HOST_MII_RST_VAL;
               end else if (step == H_REG_RST) begin
                  next_reg_addr = phy_init_pkg::OFS_RESET_CTRL;
                  next_wdata    = phy_init_pkg::HOST_REG_RST_VAL;
               end else if (step == H_AN_START) begin
                  next_reg_addr = phy_init_pkg::OFS_BASIC_CTRL;
                  next_wdata    = phy_init_pkg::HOST_AN_START_VAL;
               end else begin
                  next_reg_addr = phy_init_pkg::OFS_BASIC_STATUS;
               end
            end else if (mif.ack) begin
               next_pend = 1'h0;
               if (step == H_MII_RST) begin
                  next_step = H_REG_RST;
               end else if (step == H_REG_RST) begin
                  next_step = H_WAIT;
                  next_cnt  = '0;
               end else if (step == H_AN_START) begin
                  next_step = H_POLL;
               end else if (mif.rdata[phy_init_pkg::BS_AN_DONE_BIT]) begin
                  next_step = H_IDLE;
                  next_busy = 1'h0;
                  next_done = 1'h1;
               end
            end else if (tmo == 5'(phy_init_pkg::ACK_TIMEOUT_CYC - 1)) begin
               // A silent device means a wrong address or a stuck reset
               next_pend  = 1'h0;
               next_step  = H_IDLE;
               next_busy  = 1'h0;
               next_error = 1'h1;
            end else begin
               next_tmo = tmo + 5'h1;
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         step  <= H_IDLE;
         cnt   <= '0;
         pend  <= 1'h0;
         tmo   <= '0;
         busy  <= 1'h0;
         done  <= 1'h0;
         error <= 1'h0;
         mif.hw_reset_n <= 1'h1;
         mif.req      <= 1'h0;
         mif.wr       <= 1'h0;
         mif.phy_addr <= '0;
         mif.reg_addr <= '0;
         mif.wdata    <= 16'h0000;
      end else if (ce) begin
         step  <= next_step;
         cnt   <= next_cnt;
         pend  <= next_pend;
         tmo   <= next_tmo;
         busy  <= next_busy;
         done  <= next_done;
         error <= next_error;
         mif.hw_reset_n <= next_hw_reset_n;
         mif.req      <= next_req;
         mif.wr       <= next_wr;
         mif.phy_addr <= next_phy_addr;
         mif.reg_addr <= next_reg_addr;
         mif.wdata    <= next_wdata;
      end
   end
endmodule : phy_init_host

// ==== sim/phy_init_assertions.sv ====
`timescale 1ns/1ps
module phy_init_assertions #(
   parameter int RST_DONE_CYC     = 20,
   parameter int REG_RST_WAIT_CYC = 10
) (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        hw_reset_n,
   input wire logic        req,
   input wire logic        wr,
   input wire logic [4:0]  phy_addr,
   input wire logic [4:0]  reg_addr,
   input wire logic [15:0] wdata,
   input wire logic        ack,
   input wire logic [15:0] rdata
);
   // One cycle of slack below and four above, for where the host's wait counter starts
   localparam int W_LO = REG_RST_WAIT_CYC - 1;
   localparam int W_HI = REG_RST_WAIT_CYC + 4;
   logic [15:0] low_cnt;
   logic [15:0] rel_cnt;
   logic [15:0] next_low_cnt;
   logic [15:0] next_rel_cnt;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   always_comb begin
      next_low_cnt = hw_reset_n ? 16'h0000 : low_cnt + 16'h0001;
      next_rel_cnt = rel_cnt;
      if (!hw_reset_n)
         next_rel_cnt = 16'h0000;
      else if (rel_cnt != 16'hFFFF)
         next_rel_cnt = rel_cnt + 16'h0001;
   end
   // Saturates so an old release never looks recent
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         low_cnt <= 16'h0000;
         rel_cnt <= 16'hFFFF;
      end else begin
         low_cnt <= next_low_cnt;
         rel_cnt <= next_rel_cnt;
      end
   end

   sequence s_mii_rst;
      req && wr && reg_addr == phy_init_pkg::OFS_BASIC_CTRL
         && wdata == phy_init_pkg::HOST_MII_RST_VAL;
   endsequence
   sequence s_reg_rst;
      req && wr && reg_addr == phy_init_pkg::OFS_RESET_CTRL
         && wdata == phy_init_pkg::HOST_REG_RST_VAL;
   endsequence
   sequence s_an_start;
      req && wr && reg_addr == phy_init_pkg::OFS_BASIC_CTRL
         && wdata == phy_init_pkg::HOST_AN_START_VAL;
   endsequence

   property p_hw_low_len;
      $rose(hw_reset_n) |-> low_cnt == 16'(phy_init_pkg::HWRST_MIN_CYC);
   endproperty
   a_hw_low_len: assert property (p_hw_low_len)
      else $error("reset pin low time wrong");
   property p_no_ack_held;
      !hw_reset_n |=> !ack;
   endproperty
   a_no_ack_held: assert property (p_no_ack_held)
      else $error("answer while held in reset");
   property p_wait_release;
      req |-> rel_cnt >= 16'(RST_DONE_CYC);
   endproperty
   a_wait_release: assert property (p_wait_release)
      else $error("request before reset interval passed");
   property p_ack_ready;
      ack |-> rel_cnt > 16'(RST_DONE_CYC);
   endproperty
   a_ack_ready: assert property (p_ack_ready)
      else $error("answer before internal reset finished");
   property p_ack_cause;
      ack |-> $past(req) && $past(hw_reset_n);
   endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("answer without request");
   property p_ack_pulse;
      ack |=> !ack && !req;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("answer not a single pulse");
   property p_reset_order;
      s_mii_rst ##1 ack |-> ##[1:16] s_reg_rst;
   endproperty
   a_reset_order: assert property (p_reset_order)
      else $error("register reset did not follow control reset");
   // Only the opening cycles of the delay; the counted end is checked below
   property p_reg_wait;
      s_reg_rst ##1 ack |=> !req [*8];
   endproperty
   a_reg_wait: assert property (p_reg_wait)
      else $error("request during register reset delay");
   property p_addr_hold;
      req |-> $stable(phy_addr);
   endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("request address moved during sequence");
   property p_an_after_wait;
      s_reg_rst ##1 ack |-> ##[W_LO:W_HI] s_an_start;
   endproperty
   a_an_after_wait: assert property (p_an_after_wait)
      else $error("negotiation start not after reset delay");
   property p_an_poll;
      s_an_start ##1 ack |-> ##[1:16]
         (req && !wr && reg_addr == phy_init_pkg::OFS_BASIC_STATUS);
   endproperty
   a_an_poll: assert property (p_an_poll)
      else $error("status not polled after negotiation start");
   property p_rdata_hold;
      hw_reset_n && $past(hw_reset_n) && !(ack && !wr) |-> $stable(rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data changed without read answer");
endmodule : phy_init_assertions

// ==== sim/tb_phy_init_sequence.sv ====
`timescale 1ns/1ps
module tb_phy_reset_and_init_sequence;
   localparam int RST_CYC  = 20;
   localparam int WAIT_CYC = 10;
   logic       clk = 1'h0;
   logic       rstn = 1'h0;
   logic       ce = 1'h1;
   logic [4:0] strap_phy_addr = 5'h0B;
   logic       strap_rmii = 1'h1;
   logic       link_up = 1'h1;
   logic       activity = 1'h0;
   logic       collision = 1'h0;
   logic       start = 1'h0;
   logic [4:0] phy_addr_cfg = 5'h0B;
   logic [4:0] phy_address;
   logic       rmii_mode, init_done, clk_run, led_primary;
   logic       col_pin, col_pin_oe, busy, done, error;
   int         n_fail = 0;
   int         comparisons = 0;

   always #10 clk = ~clk;

   phy_mgmt_if mif ();
   phy_init_device #(.RST_DONE_CYC(RST_CYC), .AN_DONE_CYC(8),
      .BLINK_CYC(4)) i_phy_init_device (.clk(clk), .rstn(rstn), .ce(ce),
      .mif(mif), .strap_phy_addr(strap_phy_addr), .strap_rmii(strap_rmii),
      .link_up(link_up), .activity(activity), .collision(collision),
      .phy_address(phy_address), .rmii_mode(rmii_mode),
      .init_done(init_done), .clk_run(clk_run), .led_primary(led_primary),
      .col_pin(col_pin), .col_pin_oe(col_pin_oe));
   phy_init_host #(.RST_DONE_CYC(RST_CYC), .REG_RST_WAIT_CYC(WAIT_CYC))
      i_phy_init_host (.clk(clk), .rstn(rstn), .ce(ce), .mif(mif),
      .start(start), .phy_addr_cfg(phy_addr_cfg), .busy(busy),
      .done(done), .error(error));
   phy_init_assertions #(.RST_DONE_CYC(RST_CYC),
      .REG_RST_WAIT_CYC(WAIT_CYC)) i_phy_init_assertions (.clk(clk),
      .rstn(rstn), .hw_reset_n(mif.hw_reset_n), .req(mif.req),
      .wr(mif.wr), .phy_addr(mif.phy_addr), .reg_addr(mif.reg_addr),
      .wdata(mif.wdata), .ack(mif.ack), .rdata(mif.rdata));

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic kick(input logic [4:0] cfg);
      @(negedge clk);
      phy_addr_cfg = cfg;
      start = 1'h1;
      @(negedge clk);
      start = 1'h0;
   endtask : kick

   task automatic wait_idle();
      int n;
      n = 0;
      while (busy !== 1'h0 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      check("host finished", 16'(n < 3000), 16'h0001);
   endtask : wait_idle

   task automatic t_first_init();
      kick(5'h0B);
      repeat (3) @(negedge clk);
      check("pin held low", 16'(mif.hw_reset_n), 16'h0000);
      check("clocks stopped", 16'(clk_run), 16'h0000);
      check("init not done", 16'(init_done), 16'h0000);
      check("col pin released", 16'(col_pin_oe), 16'h0000);
      wait_idle();
      check("done", 16'({done, error}), 16'h0002);
      check("address", 16'(phy_address), 16'h000B);
      check("mode", 16'(rmii_mode), 16'h0001);
      check("clocks run", 16'({clk_run, init_done}), 16'h0003);
      check("led link", 16'(led_primary), 16'h0001);
      $display("test first_init finished");
   endtask : t_first_init

   task automatic t_restrap();
      strap_phy_addr = 5'h14;
      strap_rmii = 1'h0;
      kick(5'h14);
      wait_idle();
      check("done again", 16'({done, error}), 16'h0002);
      check("new address", 16'(phy_address), 16'h0014);
      check("mii mode", 16'(rmii_mode), 16'h0000);
      $display("test restrap finished");
   endtask : t_restrap

   task automatic t_leds();
      int lows;
      lows = 0;
      collision = 1'h1;
      repeat (2) @(negedge clk);
      check("col shown", 16'({col_pin_oe, col_pin}), 16'h0003);
      collision = 1'h0;
      activity = 1'h1;
      repeat (2) @(negedge clk);
      check("col idle", 16'(col_pin), 16'h0000);
      repeat (16) begin
         @(negedge clk);
         if (led_primary === 1'h0)
            lows++;
      end
      check("blink lows", 16'(lows), 16'h0008);
      activity = 1'h0;
      $display("test leds finished");
   endtask : t_leds

   task automatic t_wrong_addr();
      kick(5'h03);
      wait_idle();
      check("refused", 16'({done, error}), 16'h0001);
      check("kept strap", 16'(phy_address), 16'h0014);
      $display("test wrong_addr finished");
   endtask : t_wrong_addr

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop

   initial begin
      repeat (16) @(negedge clk);
      rstn = 1'h1;
      t_first_init();
      t_restrap();
      t_leds();
      t_wrong_addr();
      report_and_stop();
   end

   // Four sequences take well under a thousand cycles each
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      $display("ERROR watchdog expired");
      report_and_stop();
   end
endmodule : tb_phy_reset_and_init_sequence
